// ===== dv/swrf_checker.sv
// assertions on the register bank ports
`timescale 1ns/100ps
`default_nettype none
module swrf_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic drive0_select_n,
	input wire logic write_protect_in_n,
	input wire logic pp_write_protect_in_n,
	input wire logic write_protect_core_n,
	input wire logic pp_write_protect_core_n,
	input wire logic [2:0] ring_event
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_one_wait: assert property (
		psel && penable && !pready |=> pready) else $error("no ready");
	chk_ready_once: assert property (
		pready |=> !pready) else $error("long ready");
	chk_err_ready: assert property (
		pslverr |-> pready) else $error("stray error");
	chk_rdata_idle: assert property (
		!pready |-> prdata == 32'h0) else $error("stray data");
	chk_wp_drive: assert property (
		!write_protect_in_n |=> !write_protect_core_n) else $error("wp lost");
	chk_wp_pp: assert property (
		!pp_write_protect_in_n |=> !pp_write_protect_core_n)
		else $error("pp wp lost");
	chk_wp_free: assert property (
		drive0_select_n && write_protect_in_n |=> write_protect_core_n)
		else $error("wp forced");
	chk_ev_pulse: assert property (
		ring_event != 3'h0 |=> (ring_event & $past(ring_event)) == 3'h0)
		else $error("long event");
endmodule : swrf_chk
bind swrf_regs swrf_chk u_chk (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .prdata, .drive0_select_n, .write_protect_in_n,
	.pp_write_protect_in_n, .write_protect_core_n, .pp_write_protect_core_n,
	.ring_event);
`default_nettype wire

// ===== dv/swrf_far.sv
// far side model: drive select, write protect and ring lines
`timescale 1ns/100ps
`default_nettype none
module swrf_far (
	input wire logic pclk,
	input wire logic sel,
	input wire logic prot,
	input wire logic train,
	output logic drive0_select_n,
	output logic write_protect_in_n,
	output logic pp_write_protect_in_n,
	output logic [2:0] ring_n = 3'h7
);
	logic [2:0] cnt_q = 3'h0;
	assign drive0_select_n = !sel;
	assign write_protect_in_n = !prot;
	assign pp_write_protect_in_n = !prot;
	// idle ring lines sit high on their pull-ups; a fall every 10 cycles
	always_ff @(posedge pclk) begin
		cnt_q <= (train && cnt_q != 3'h4) ? cnt_q + 3'h1 : 3'h0;
		if (!train)
			ring_n <= 3'h7;
		else if (cnt_q == 3'h4)
			ring_n <= ~ring_n;
	end
endmodule : swrf_far
`default_nettype wire

// ===== dv/test_swrf_regs.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
module test_swrf_regs;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, wr = 0, sel = 0, prot = 0, train = 0;
	logic d0_n, wp_n, ppwp_n, wpc_n, ppwpc_n;
	logic [7:0] wd = 8'h0;
	logic [2:0] rn, rf_n, rev;
	int n_errors = 0, checks = 0;
	initial forever #4 pclk = ~pclk;
	swrf_regs #(.GAP_CYC(20), .TRAIN_CYC(100)) dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ser2_fifo_ctrl_wr(wr), .ser2_fifo_ctrl_data(wd),
		.drive0_select_n(d0_n), .write_protect_in_n(wp_n),
		.pp_write_protect_in_n(ppwp_n), .write_protect_core_n(wpc_n),
		.pp_write_protect_core_n(ppwpc_n), .ring_in_n(rn[0]),
		.ring_ind_port1_n(rn[1]), .ring_ind_port2_n(rn[2]),
		.ring_filtered_n(rf_n), .ring_event(rev));
	swrf_far far (.pclk, .sel, .prot, .train, .drive0_select_n(d0_n),
		.write_protect_in_n(wp_n), .pp_write_protect_in_n(ppwp_n),
		.ring_n(rn));
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one bus cycle; an idle edge after it keeps drivers single per step
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			n_errors++;
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task automatic wait_ev;
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge pclk);
			if (rev === 3'h7)
				break;
		end
		if (i == 300) begin
			n_errors++;
			give_verdict();
		end
	endtask : wait_ev
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int i = 0; i < 3; i++) begin
			apb(0, 12'h310 + 12'(4 * i), 8'h0);
			chk(rd, 32'h0);
		end
		chk(rf_n, 32'h7);
		$display("reset values done");
	endtask : t_reset
	task automatic t_copy;
		wd <= 8'hFF;
		wr <= 1;
		@(posedge pclk);
		wr <= 0;
		apb(0, 12'h310, 8'h0);
		chk(rd, 32'hCF);
		apb(1, 12'h310, 8'h00);
		apb(0, 12'h310, 8'h0);
		chk(rd, 32'hCF);
		wd <= 8'h4D;
		wr <= 1;
		@(posedge pclk);
		wr <= 0;
		apb(0, 12'h310, 8'h0);
		chk(rd, 32'h4D);
		apb(0, 12'h31C, 8'h0);
		chk(er, 32'h1);
		$display("fifo copy done");
	endtask : t_copy
	task automatic t_wp;
		apb(1, 12'h314, 8'hFF);
		apb(0, 12'h314, 8'h0);
		chk(rd, 32'h1);
		sel <= 1;
		repeat (3) @(posedge pclk);
		chk({wpc_n, ppwpc_n}, 32'h0);
		sel <= 0;
		repeat (3) @(posedge pclk);
		chk({wpc_n, ppwpc_n}, 32'h3);
		apb(1, 12'h314, 8'h0);
		sel <= 1;
		repeat (3) @(posedge pclk);
		chk({wpc_n, ppwpc_n}, 32'h3);
		prot <= 1;
		repeat (3) @(posedge pclk);
		chk({wpc_n, ppwpc_n}, 32'h0);
		sel <= 0;
		prot <= 0;
		$display("write protect done");
	endtask : t_wp
	task automatic t_ring;
		apb(1, 12'h318, 8'hFF);
		apb(0, 12'h318, 8'h0);
		chk(rd, 32'h7);
		train <= 1;
		wait_ev();
		chk(rf_n, 32'h0);
		train <= 0;
		repeat (40) @(posedge pclk);
		chk(rf_n, 32'h7);
		apb(1, 12'h318, 8'h0);
		train <= 1;
		wait_ev();
		chk(rf_n, 32'h7);
		train <= 0;
		$display("ring filter done");
	endtask : t_ring
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_reset();
		t_copy();
		t_wp();
		t_ring();
		give_verdict();
	end
endmodule : test_swrf_regs
`default_nettype wire

// ===== pkg/swrf_defs.svh
// constants of the shadow, write-protect and ring filter register bank
`ifndef SWRF_DEFS_SVH
`define SWRF_DEFS_SVH

// register indices; byte address is four times the index
`define SWRF_IDX_SER2_COPY 8'hC4
`define SWRF_IDX_WP_OVR 8'hC5
`define SWRF_IDX_RING_CTL 8'hC6

// reset values
`define SWRF_RST_SER2_COPY 8'h00
`define SWRF_RST_WP_OVR 8'h00
`define SWRF_RST_RING_CTL 8'h00

// serial fifo control copy fields
`define SWRF_FC_RXTRIG_HI 7
`define SWRF_FC_RXTRIG_LO 6
`define SWRF_FC_DMA 3
`define SWRF_FC_TXCLR 2
`define SWRF_FC_RXCLR 1
`define SWRF_FC_EN 0
`define SWRF_FC_KEEP_MASK 8'hCF

// write protect override and ring filter fields
`define SWRF_WP_BIT 0
`define SWRF_WP_MASK 8'h01
`define SWRF_RING_MASK 8'h07

// timing
`define SWRF_CLK_HZ 125000000
`define SWRF_RING_MIN_HZ 15
`define SWRF_TRAIN_MS 200
`define SWRF_MS_PER_S 1000

`endif

// ===== pkg/swrf_pkg.sv
// types of the shadow, write-protect and ring filter register bank
package swrf_pkg;
	typedef enum logic [1:0] {
		SWRF_REG_SER2 = 2'b00,
		SWRF_REG_WP = 2'b01,
		SWRF_REG_RING = 2'b10,
		SWRF_REG_NONE = 2'b11
	} swrf_reg_t;
	typedef logic [7:0] swrf_byte_t;
endpackage : swrf_pkg

// ===== src/swrf_regs.sv
// shadow, write-protect override and ring filter register bank on apb
//
// How it works
// - a read-only register copies the second serial port fifo control.
// - the override bit forces write protect active while drive 0 is selected.
// - the override acts on both the drive path and the parallel port path.
// - override bits 7:1 read zero and the register resets to zero.
// - the ring filter register is read/write with bits 7:3 reserved.
// - bit 0 picks the event of ring_in_n; ring_filtered_n is always filtered for a 15 Hz train lasting 200 ms into a low pulse.
// - with filtering on, the falling edge of that low pulse is the ring event.
// - with filtering off, any falling edge on the pin is the ring event.
// - bit 1 picks the event of ring_ind_port1_n the same way.
// - bit 2 picks the event of ring_ind_port2_n the same way.
// - core write protect combines drive 0 select, override and drive input.
`timescale 1ns/100ps
`default_nettype none
`include "swrf_defs.svh"

module swrf_regs #(
	parameter int unsigned ADDR_W = 12,
	parameter int unsigned CNT_W = 26,
	// longest gap between falling edges of a qualifying train
	parameter int unsigned GAP_CYC = `SWRF_CLK_HZ / `SWRF_RING_MIN_HZ,
	// least train length before the filtered pulse starts
	parameter int unsigned TRAIN_CYC =
		(`SWRF_CLK_HZ / `SWRF_MS_PER_S) * `SWRF_TRAIN_MS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ser2_fifo_ctrl_wr,
	input wire swrf_pkg::swrf_byte_t ser2_fifo_ctrl_data,
	input wire logic drive0_select_n,
	input wire logic write_protect_in_n,
	input wire logic pp_write_protect_in_n,
	output logic write_protect_core_n,
	output logic pp_write_protect_core_n,
	input wire logic ring_in_n,
	input wire logic ring_ind_port1_n,
	input wire logic ring_ind_port2_n,
	output logic [2:0] ring_filtered_n,
	output logic [2:0] ring_event
);
	import swrf_pkg::*;

	localparam int unsigned NCH = 3;

	////////////////////////////////////////////////////////////////////
	// elaboration checks

	if (ADDR_W < 10) begin : g_chk_addr
		$error("swrf_regs: ADDR_W too small for the register map");
	end
	if (GAP_CYC < 1 || TRAIN_CYC < 1) begin : g_chk_cyc
		$error("swrf_regs: cycle counts must be at least one");
	end
	if (CNT_W > 31 || GAP_CYC >= (1 << CNT_W) ||
		TRAIN_CYC >= (1 << CNT_W)) begin : g_chk_cnt
		$error("swrf_regs: CNT_W cannot hold the cycle counts");
	end

	////////////////////////////////////////////////////////////////////
	// address decode

	function automatic swrf_reg_t swrf_decode(
		input logic [ADDR_W-1:0] addr
	);
		logic [ADDR_W-1:0] a_ser2;
		logic [ADDR_W-1:0] a_wp;
		logic [ADDR_W-1:0] a_ring;
		a_ser2 = ADDR_W'({`SWRF_IDX_SER2_COPY, 2'b00});
		a_wp = ADDR_W'({`SWRF_IDX_WP_OVR, 2'b00});
		a_ring = ADDR_W'({`SWRF_IDX_RING_CTL, 2'b00});
		if (addr == a_ser2) begin
			swrf_decode = SWRF_REG_SER2;
		end else if (addr == a_wp) begin
			swrf_decode = SWRF_REG_WP;
		end else if (addr == a_ring) begin
			swrf_decode = SWRF_REG_RING;
		end else begin
			swrf_decode = SWRF_REG_NONE;
		end
	endfunction : swrf_decode

	////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, answer on the second access cycle

	logic access;
	logic done;
	logic wr_done;
	swrf_reg_t sel_reg;

	assign access = psel & penable;
	assign done = access & pready;
	assign wr_done = done & pwrite;
	assign sel_reg = swrf_decode(paddr);

	swrf_byte_t ser2_copy_q;
	swrf_byte_t wp_ovr_q;
	swrf_byte_t ring_ctl_q;
	swrf_byte_t rd_byte;

	always_comb begin
		rd_byte = 8'h00;
		case (sel_reg)
			SWRF_REG_SER2: rd_byte = ser2_copy_q;
			SWRF_REG_WP: rd_byte = wp_ovr_q;
			SWRF_REG_RING: rd_byte = ring_ctl_q;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (access && !pready) begin
			pready <= 1'b1;
			pslverr <= (sel_reg == SWRF_REG_NONE);
			prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// serial fifo control copy

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser2_copy_q <= `SWRF_RST_SER2_COPY;
		end else if (ser2_fifo_ctrl_wr) begin
			ser2_copy_q <= ser2_fifo_ctrl_data & `SWRF_FC_KEEP_MASK;
		end
	end
	// no host write path exists for the copy

	////////////////////////////////////////////////////////////////////
	// write protect override

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_ovr_q <= `SWRF_RST_WP_OVR;
		end else if (wr_done && sel_reg == SWRF_REG_WP) begin
			wp_ovr_q <= pwdata[7:0] & `SWRF_WP_MASK;
		end
	end

	logic force_wp;
	assign force_wp = wp_ovr_q[`SWRF_WP_BIT] & ~drive0_select_n;

	// same override on the parallel port path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_protect_core_n <= 1'b1;
			pp_write_protect_core_n <= 1'b1;
		end else begin
			write_protect_core_n <= write_protect_in_n & ~force_wp;
			pp_write_protect_core_n <= pp_write_protect_in_n & ~force_wp;
		end
	end

	////////////////////////////////////////////////////////////////////
	// ring filter select and per-input filters

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_ctl_q <= `SWRF_RST_RING_CTL;
		end else if (wr_done && sel_reg == SWRF_REG_RING) begin
			ring_ctl_q <= pwdata[7:0] & `SWRF_RING_MASK;
		end
	end

	logic [NCH-1:0] ring_pins_n;
	assign ring_pins_n = {ring_ind_port2_n, ring_ind_port1_n, ring_in_n};

	localparam logic [CNT_W-1:0] GAP_MAX = CNT_W'(GAP_CYC);
	localparam logic [CNT_W-1:0] TRAIN_MIN = CNT_W'(TRAIN_CYC);

	for (genvar ch = 0; ch < NCH; ch++) begin : g_ring
		logic prev_q;
		logic [CNT_W-1:0] gap_q;
		logic [CNT_W-1:0] train_q;
		logic fall;
		logic in_train;
		logic filt_d;

		assign fall = prev_q & ~ring_pins_n[ch];
		// a train lives while edges come no further apart than the gap
		assign in_train = (gap_q < GAP_MAX);
		// low for the train once it has lasted long enough
		assign filt_d = ~(in_train && train_q >= TRAIN_MIN);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				prev_q <= 1'b1;
			end else begin
				prev_q <= ring_pins_n[ch];
			end
		end

		// idle reset value: no recent edge, so no train
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				gap_q <= GAP_MAX;
			end else if (fall) begin
				gap_q <= '0;
			end else if (in_train) begin
				gap_q <= gap_q + 1'b1;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				train_q <= '0;
			end else if (!in_train) begin
				train_q <= '0;
			end else if (train_q < TRAIN_MIN) begin
				train_q <= train_q + 1'b1;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ring_filtered_n[ch] <= 1'b1;
			end else begin
				ring_filtered_n[ch] <= filt_d;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ring_event[ch] <= 1'b0;
			end else if (ring_ctl_q[ch]) begin
				// leading edge of the filtered pulse
				ring_event[ch] <= ring_filtered_n[ch] & ~filt_d;
			end else begin
				ring_event[ch] <= fall;
			end
		end
	end

endmodule : swrf_regs
`default_nettype wire
